// File: bench/rda_align_assertions.sv
`timescale 1ns/10ps
// ==========
// Port checker for the alignment block.
module rda_align_assertions (
  // Clock, reset and host control
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  input wire rda_pkg::rda_mode_t MODE_IN,
  input wire logic TRIGGER_IN,
  input wire logic USE_FIXED_IN,
  input wire rda_pkg::rda_delay_t FIXED_DELAY_IN,
  // Stream and gating inputs
  input wire logic SAMPLE_VALID_IN,
  input wire logic VOICE_ACTIVITY_FLAG_IN,
  input wire logic GAIN_REQ_ASR_IN,
  input wire logic GAIN_REQ_COMM_IN,
  // Outputs
  input wire logic ALIGNED_VALID_OUT,
  input wire rda_pkg::rda_delay_t APPLIED_DELAY_OUT,
  input wire logic ESTIMATING_OUT,
  input wire logic IC_ADAPT_EN_OUT,
  input wire logic GAIN_UPD_ASR_OUT,
  input wire logic GAIN_UPD_COMM_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!NRST_IN);
  sequence boot_s;
    $rose(NRST_IN);
  endsequence
  sequence fixed_req_s;
    TRIGGER_IN && USE_FIXED_IN && MODE_IN == rda_pkg::RDA_MODE_MANUAL && !ESTIMATING_OUT
      && $past(NRST_IN, 3);
  endsequence
  valid_follow_a: assert property (SAMPLE_VALID_IN |=> ALIGNED_VALID_OUT)
    else $error("aligned valid missing");
  valid_only_a: assert property ($past(NRST_IN) && ALIGNED_VALID_OUT |->
    $past(SAMPLE_VALID_IN)) else $error("aligned valid without sample");
  startup_est_a: assert property (boot_s ##0 MODE_IN != rda_pkg::RDA_MODE_MANUAL
    |-> ##[1:4] ESTIMATING_OUT) else $error("no estimate after reset");
  manual_idle_a: assert property (boot_s ##0 MODE_IN == rda_pkg::RDA_MODE_MANUAL
    |-> (!ESTIMATING_OUT)[*4]) else $error("manual mode not idle");
  fixed_apply_a: assert property (fixed_req_s |=> APPLIED_DELAY_OUT == {
    ($past(FIXED_DELAY_IN.amount) > rda_pkg::MAX_DELAY) ? rda_pkg::MAX_DELAY
    : $past(FIXED_DELAY_IN.amount), $past(FIXED_DELAY_IN.path)}) else $error("fixed delay");
  delay_clamp_a: assert property (APPLIED_DELAY_OUT.amount <= rda_pkg::MAX_DELAY)
    else $error("delay above maximum");
  delay_hold_a: assert property ($changed(APPLIED_DELAY_OUT) |-> $past(TRIGGER_IN)
    || $past(ESTIMATING_OUT) || $past(ESTIMATING_OUT, 2)) else $error("delay changed unasked");
  ic_gate_a: assert property ($past(NRST_IN) |-> IC_ADAPT_EN_OUT ==
    !$past(VOICE_ACTIVITY_FLAG_IN)) else $error("canceller adapt gate");
  asr_gate_a: assert property ($past(NRST_IN) |-> GAIN_UPD_ASR_OUT ==
    $past(GAIN_REQ_ASR_IN && !VOICE_ACTIVITY_FLAG_IN)) else $error("recognition gain gate");
  comm_gate_a: assert property ($past(NRST_IN) |-> GAIN_UPD_COMM_OUT ==
    $past(GAIN_REQ_COMM_IN)) else $error("comms gain update");
endmodule : rda_align_assertions
bind rda_align rda_align_assertions i_chk (
  .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .MODE_IN(MODE_IN), .TRIGGER_IN(TRIGGER_IN),
  .USE_FIXED_IN(USE_FIXED_IN), .FIXED_DELAY_IN(FIXED_DELAY_IN),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .VOICE_ACTIVITY_FLAG_IN(VOICE_ACTIVITY_FLAG_IN),
  .GAIN_REQ_ASR_IN(GAIN_REQ_ASR_IN), .GAIN_REQ_COMM_IN(GAIN_REQ_COMM_IN),
  .ALIGNED_VALID_OUT(ALIGNED_VALID_OUT), .APPLIED_DELAY_OUT(APPLIED_DELAY_OUT),
  .ESTIMATING_OUT(ESTIMATING_OUT), .IC_ADAPT_EN_OUT(IC_ADAPT_EN_OUT),
  .GAIN_UPD_ASR_OUT(GAIN_UPD_ASR_OUT), .GAIN_UPD_COMM_OUT(GAIN_UPD_COMM_OUT)
);

// File: bench/rda_align_tb_top.sv
`timescale 1ns/10ps
module rda_align_tb_top;
  // ==========
  // Bench state
  logic clk, nrst, sv, voice_activity_flag, gra, grc, av, est, ic, ga, gc, trig, fx, chk;
  rda_pkg::rda_stereo_t mic_d, ref_d, mic_o, ref_o;
  rda_pkg::rda_stereo_t mic_h [8192];
  rda_pkg::rda_stereo_t ref_h [8192];
  rda_pkg::rda_delay_t app, fdly, xd, d;
  rda_pkg::rda_mode_t mode;
  int err_count = 0;
  int n_checks = 0;
  int ns, nout, cyc, i, b, up;
  logic pv, pa, pc;
  integer seed = 32'h2233d7d8;
  rda_align i_dut (
    .CLOCK_IN(clk), .NRST_IN(nrst), .SAMPLE_VALID_IN(sv), .MIC_IN(mic_d), .REF_IN(ref_d),
    .MODE_IN(mode), .TRIGGER_IN(trig), .USE_FIXED_IN(fx), .FIXED_DELAY_IN(fdly),
    .VOICE_ACTIVITY_FLAG_IN(voice_activity_flag), .GAIN_REQ_ASR_IN(gra), .GAIN_REQ_COMM_IN(grc),
    .ALIGNED_VALID_OUT(av), .MIC_OUT(mic_o), .REF_OUT(ref_o), .APPLIED_DELAY_OUT(app),
    .ESTIMATING_OUT(est), .IC_ADAPT_EN_OUT(ic), .GAIN_UPD_ASR_OUT(ga), .GAIN_UPD_COMM_OUT(gc)
  );
  rda_host_model i_host (
    .clk_in(clk), .mode_out(mode), .trigger_out(trig), .use_fixed_out(fx), .fixed_out(fdly)
  );
  // ==========
  // Expectations, checks and drivers
  function automatic rda_pkg::rda_delay_t est_of(input int tm, input int tr);
    est_of.path = (tm >= tr) ? rda_pkg::PATH_REF : rda_pkg::PATH_MIC;
    est_of.amount = 12'((tm >= tr) ? tm - tr : tr - tm);
  endfunction : est_of
  function automatic rda_pkg::rda_delay_t fix_of(input rda_pkg::rda_delay_t v);
    fix_of = v;
    if (v.amount > rda_pkg::MAX_DELAY) fix_of.amount = rda_pkg::MAX_DELAY;
  endfunction : fix_of
  task automatic fail(input string s);
    err_count++;
    $display("[FAIL] t=%0t %s", $time, s);
  endtask : fail
  task automatic cmp_smp(input rda_pkg::rda_stereo_t a, input rda_pkg::rda_stereo_t e);
    n_checks++;
    if (a !== e) fail("sample");
  endtask : cmp_smp
  task automatic cmp_dly(input rda_pkg::rda_delay_t a, input rda_pkg::rda_delay_t e);
    n_checks++;
    if (a !== e) fail("delay");
  endtask : cmp_dly
  task automatic cmp_bit(input logic a, input logic e);
    n_checks++;
    if (a !== e) fail("flag");
  endtask : cmp_bit
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic do_reset;
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    ns = 0;
    nout = 0;
    nrst <= 1'b1;
  endtask : do_reset
  // Left channels stay below the onset level except at the marked sample.
  task automatic smp(input int om, input int orf);
    rda_pkg::rda_stereo_t m, r;
    m = {(ns == om) ? 16'h7000 : {4'h0, ns[11:0]}, 16'($random(seed))};
    r = {(ns == orf) ? 16'h7000 : {4'h0, ns[11:0]}, 16'($random(seed))};
    @(posedge clk);
    sv <= 1'b1;
    mic_d <= m;
    ref_d <= r;
    mic_h[ns[12:0]] = m;
    ref_h[ns[12:0]] = r;
    ns++;
    @(posedge clk);
    sv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : smp
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    voice_activity_flag <= 1'($random(seed));
    gra <= 1'($random(seed));
    grc <= 1'($random(seed));
    cyc++;
    if (cyc == 60000) begin
      fail("timeout");
      wrap_up;
    end
  end
  // Gating outputs follow the inputs seen one edge earlier.
  always @(posedge clk) begin
    if (nrst !== 1'b1) begin
      up = 0;
    end else begin
      if (up > 0) begin
        cmp_bit(ic, !pv);
        cmp_bit(ga, pa && !pv);
        cmp_bit(gc, pc);
      end
      up++;
    end
    pv = voice_activity_flag;
    pa = gra;
    pc = grc;
  end
  always @(posedge clk) if (nrst === 1'b1 && av === 1'b1) begin
    if (chk && nout >= int'(xd.amount)) begin
      cmp_smp(mic_o, mic_h[13'(nout - (xd.path ? int'(xd.amount) : 0))]);
      cmp_smp(ref_o, ref_h[13'(nout - (xd.path ? 0 : int'(xd.amount)))]);
    end
    nout++;
  end
  // ==========
  // Main sequence
  initial begin
    {sv, voice_activity_flag, gra, grc, chk} = '0;
    mic_d = '0;
    ref_d = '0;
    xd = '0;
    do_reset;
    repeat (2100) smp(137, 100);
    cmp_dly(app, est_of(137, 100));
    repeat (100) smp(-1, -1);
    cmp_dly(app, est_of(137, 100));
    $display("startup estimate done");
    i_host.set_mode(rda_pkg::RDA_MODE_MANUAL);
    do_reset;
    repeat (6) @(posedge clk);
    cmp_bit(est, 1'b0);
    chk = 1'b1;
    for (i = 0; i < 8; i++) begin
      d = {12'($random(seed) & 63), 1'($random(seed))};
      if (i == 0) d.amount = 12'h000;
      if (i == 6) d.amount = 12'd2400;
      if (i == 7) d.amount = 12'hfff;
      i_host.fire(1'b1, d);
      @(posedge clk);
      xd = fix_of(d);
      cmp_dly(app, xd);
      repeat (80) smp(-1, -1);
      cmp_dly(app, xd);
    end
    chk = 1'b0;
    $display("fixed delays done");
    b = ns;
    i_host.fire(1'b0, '0);
    for (i = 0; i < 2100; i++) begin
      smp(b + 60, b + 89);
      if (i == 1) cmp_bit(est, 1'b1);
      if (i == 900) i_host.fire(1'b1, {12'd9, rda_pkg::PATH_REF});
    end
    cmp_dly(app, est_of(b + 60, b + 89));
    $display("manual estimate done");
    i_host.set_mode(rda_pkg::RDA_MODE_AUTO);
    repeat (5) smp(-1, -1);
    cmp_bit(est, 1'b1);
    i_host.fire(1'b1, {12'd5, rda_pkg::PATH_MIC});
    @(posedge clk);
    cmp_dly(app, est_of(b + 60, b + 89));
    $display("auto mode done");
    wrap_up;
  end
endmodule : rda_align_tb_top

// File: bench/rda_host_model.sv
`timescale 1ns/10ps
// ==========
// Host that selects the mode and issues triggers.
module rda_host_model (
  // Clock
  input wire logic clk_in,
  // Commands
  output rda_pkg::rda_mode_t mode_out,
  output logic trigger_out,
  output logic use_fixed_out,
  output rda_pkg::rda_delay_t fixed_out
);
  initial begin
    mode_out = rda_pkg::RDA_MODE_STARTUP;
    trigger_out = 1'b0;
    use_fixed_out = 1'b0;
    fixed_out = '0;
  end
  task automatic set_mode(input rda_pkg::rda_mode_t m);
    @(posedge clk_in);
    mode_out <= m;
  endtask : set_mode
  // The trigger is one cycle long; selector and delay stand while it is high.
  task automatic fire(input logic f, input rda_pkg::rda_delay_t d);
    @(posedge clk_in);
    use_fixed_out <= f;
    fixed_out <= d;
    trigger_out <= 1'b1;
    @(posedge clk_in);
    trigger_out <= 1'b0;
  endtask : fire
endmodule : rda_host_model

// File: rtl/rda_align.sv
`timescale 1ns/10ps
// Functional notes
// - Delay 0 to 150 ms on either path.
// - Delay counted in samples, 0 to 2400.
// - Shift one stream, pass both aligned.
// - Automatic mode estimates continuously from reset.
// - Manual mode idles until trigger, then acts.
// - Manual delay held until host changes it.
// - Start-up mode is default, estimates once.
// - After start-up estimate, changes only on request.
// - Canceller adapts only without speech.
// - Recognition gain frozen during speech; separate states.
module rda_align (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic NRST_IN,
  // Sample streams
  input wire logic SAMPLE_VALID_IN,
  input wire rda_pkg::rda_stereo_t MIC_IN,
  input wire rda_pkg::rda_stereo_t REF_IN,
  // Host control
  input wire rda_pkg::rda_mode_t MODE_IN,
  input wire logic TRIGGER_IN,
  input wire logic USE_FIXED_IN,
  input wire rda_pkg::rda_delay_t FIXED_DELAY_IN,
  // Gating inputs
  input wire logic VOICE_ACTIVITY_FLAG_IN,
  input wire logic GAIN_REQ_ASR_IN,
  input wire logic GAIN_REQ_COMM_IN,
  // Aligned streams to the echo canceller
  output logic ALIGNED_VALID_OUT,
  output rda_pkg::rda_stereo_t MIC_OUT,
  output rda_pkg::rda_stereo_t REF_OUT,
  // Status
  output rda_pkg::rda_delay_t APPLIED_DELAY_OUT,
  output logic ESTIMATING_OUT,
  output logic IC_ADAPT_EN_OUT,
  output logic GAIN_UPD_ASR_OUT,
  output logic GAIN_UPD_COMM_OUT
);

  // ==========================================================================
  // Clamp helper
  // ==========================================================================
  function automatic logic [rda_pkg::DELAY_W-1:0] clamp(input logic [11:0] d);
    clamp = (d > rda_pkg::MAX_DELAY) ? rda_pkg::MAX_DELAY : d;
  endfunction : clamp

  // ==========================================================================
  // Control state machine
  // ==========================================================================
  typedef enum {ST_BOOT, ST_IDLE, ST_EST, ST_HOLD} rda_state_t;

  rda_state_t state, next_state;
  rda_pkg::rda_delay_t applied, next_applied;
  logic est_start;
  logic est_busy;
  logic est_done;
  rda_pkg::rda_delay_t est_res;

  rda_estimator u_est (
    .CLOCK_IN(CLOCK_IN),
    .nrst(NRST_IN),
    .start_in(est_start),
    .sample_in(SAMPLE_VALID_IN),
    .mic_in(MIC_IN.left),
    .ref_in(REF_IN.left),
    .busy_out(est_busy),
    .done_out(est_done),
    .result_out(est_res)
  );

  always_comb begin
    next_state = state;
    next_applied = applied;
    est_start = 1'b0;
    case (state)
      ST_BOOT: begin
        // Start-up and automatic modes both estimate right after reset.
        if (MODE_IN == rda_pkg::RDA_MODE_MANUAL) begin
          next_state = ST_IDLE;
        end else begin
          est_start = 1'b1;
          next_state = ST_EST;
        end
      end
      ST_IDLE, ST_HOLD: begin
        if (MODE_IN == rda_pkg::RDA_MODE_AUTO) begin
          est_start = 1'b1;
          next_state = ST_EST;
        end else if (TRIGGER_IN && USE_FIXED_IN) begin
          next_applied.path = FIXED_DELAY_IN.path;
          next_applied.amount = clamp(FIXED_DELAY_IN.amount);
          next_state = ST_HOLD;
        end else if (TRIGGER_IN) begin
          est_start = 1'b1;
          next_state = ST_EST;
        end
      end
      ST_EST: begin
        if (est_done) begin
          next_applied = est_res;
        end
        if (!est_busy && !est_done) begin
          if (MODE_IN == rda_pkg::RDA_MODE_AUTO) begin
            est_start = 1'b1;
          end else begin
            next_state = ST_HOLD;
          end
        end
      end
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state <= ST_BOOT;
      applied <= '{amount: rda_pkg::DELAY_RESET, path: rda_pkg::PATH_REF};
    end else begin
      state <= next_state;
      applied <= next_applied;
    end
  end

  // ==========================================================================
  // Delay line
  // ==========================================================================
  // Both streams are stored every sample, so a change of delayed path still
  // finds the right history; the delayed path reads back by the applied
  // amount, the other path gets a single stage to match latency.
  rda_pkg::rda_stereo_t mem_mic [rda_pkg::DEPTH];
  rda_pkg::rda_stereo_t mem_ref [rda_pkg::DEPTH];
  logic [rda_pkg::ADDR_W-1:0] wr_ptr, next_wr_ptr;
  logic [rda_pkg::ADDR_W-1:0] rd_ptr;
  rda_pkg::rda_stereo_t wr_data;
  rda_pkg::rda_stereo_t rd_data;
  logic valid_d, next_valid_d;
  rda_pkg::rda_stereo_t mic_q, next_mic_q, ref_q, next_ref_q;

  always_comb begin
    wr_data = (applied.path == rda_pkg::PATH_MIC) ? MIC_IN : REF_IN;
    rd_ptr = wr_ptr - applied.amount;
    if (applied.amount == '0) begin
      rd_data = wr_data;
    end else if (applied.path == rda_pkg::PATH_MIC) begin
      rd_data = mem_mic[rd_ptr];
    end else begin
      rd_data = mem_ref[rd_ptr];
    end
    next_wr_ptr = wr_ptr;
    next_valid_d = SAMPLE_VALID_IN;
    next_mic_q = mic_q;
    next_ref_q = ref_q;
    if (SAMPLE_VALID_IN) begin
      next_wr_ptr = wr_ptr + 1'b1;
      if (applied.path == rda_pkg::PATH_MIC) begin
        next_mic_q = rd_data;
        next_ref_q = REF_IN;
      end else begin
        next_ref_q = rd_data;
        next_mic_q = MIC_IN;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (SAMPLE_VALID_IN) begin
      mem_mic[wr_ptr] <= MIC_IN;
      mem_ref[wr_ptr] <= REF_IN;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_ptr <= '0;
      valid_d <= 1'b0;
      mic_q <= '0;
      ref_q <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      valid_d <= next_valid_d;
      mic_q <= next_mic_q;
      ref_q <= next_ref_q;
    end
  end

  // ==========================================================================
  // Voice activity gating
  // ==========================================================================
  logic ic_en, next_ic_en, g_asr, next_g_asr, g_comm, next_g_comm;
  logic est_q, next_est_q;

  always_comb begin
    next_ic_en = !VOICE_ACTIVITY_FLAG_IN;
    next_g_asr = GAIN_REQ_ASR_IN && !VOICE_ACTIVITY_FLAG_IN;
    next_g_comm = GAIN_REQ_COMM_IN;
    next_est_q = (next_state == ST_EST);
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ic_en <= 1'b0;
      g_asr <= 1'b0;
      g_comm <= 1'b0;
      est_q <= 1'b0;
    end else begin
      ic_en <= next_ic_en;
      g_asr <= next_g_asr;
      g_comm <= next_g_comm;
      est_q <= next_est_q;
    end
  end

  assign ALIGNED_VALID_OUT = valid_d;
  assign MIC_OUT = mic_q;
  assign REF_OUT = ref_q;
  assign APPLIED_DELAY_OUT = applied;
  assign ESTIMATING_OUT = est_q;
  assign IC_ADAPT_EN_OUT = ic_en;
  assign GAIN_UPD_ASR_OUT = g_asr;
  assign GAIN_UPD_COMM_OUT = g_comm;

endmodule : rda_align

// File: rtl/rda_estimator.sv
`timescale 1ns/10ps
module rda_estimator (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic nrst,
  // Control
  input wire logic start_in,
  input wire logic sample_in,
  input wire logic signed [rda_pkg::SAMPLE_W-1:0] mic_in,
  input wire logic signed [rda_pkg::SAMPLE_W-1:0] ref_in,
  // Result
  output logic busy_out,
  output logic done_out,
  output rda_pkg::rda_delay_t result_out
);

  // ==========================================================================
  // Envelope correlator
  // ==========================================================================
  // Tracks the onset of energy in each stream; the lag between the two first
  // strong onsets of a scan window is the offset. Positive means the mic
  // lags, so the reference path is delayed.
  function automatic logic [rda_pkg::SAMPLE_W-1:0] mag(input logic signed [15:0] s);
    mag = s[15] ? 16'(-s) : 16'(s);
  endfunction : mag

  localparam logic [15:0] ONSET = 16'h1000;

  logic busy, next_busy, done, next_done;
  logic [rda_pkg::SCAN_W-1:0] cnt, next_cnt;
  logic [rda_pkg::SCAN_W-1:0] t_mic, next_t_mic, t_ref, next_t_ref;
  logic seen_mic, next_seen_mic, seen_ref, next_seen_ref;
  rda_pkg::rda_delay_t res, next_res;
  logic signed [rda_pkg::LAG_W-1:0] lag;
  logic [rda_pkg::LAG_W-1:0] alag;

  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_cnt = cnt;
    next_t_mic = t_mic;
    next_t_ref = t_ref;
    next_seen_mic = seen_mic;
    next_seen_ref = seen_ref;
    next_res = res;
    lag = $signed({1'b0, t_mic}) - $signed({1'b0, t_ref});
    alag = lag[rda_pkg::LAG_W-1] ? rda_pkg::LAG_W'(-lag) : rda_pkg::LAG_W'(lag);
    if (start_in) begin
      next_busy = 1'b1;
      next_cnt = '0;
      next_seen_mic = 1'b0;
      next_seen_ref = 1'b0;
    end else if (busy && sample_in) begin
      if (!seen_mic && mag(mic_in) >= ONSET) begin
        next_seen_mic = 1'b1;
        next_t_mic = cnt;
      end
      if (!seen_ref && mag(ref_in) >= ONSET) begin
        next_seen_ref = 1'b1;
        next_t_ref = cnt;
      end
      next_cnt = cnt + 1'b1;
      if (cnt == rda_pkg::SCAN_LEN - 1'b1) begin
        next_busy = 1'b0;
        next_done = seen_mic && seen_ref;
        next_res.path = lag[rda_pkg::LAG_W-1] ? rda_pkg::PATH_MIC : rda_pkg::PATH_REF;
        if (alag > rda_pkg::LAG_W'(rda_pkg::MAX_DELAY)) begin
          next_res.amount = rda_pkg::MAX_DELAY;
        end else begin
          next_res.amount = alag[rda_pkg::DELAY_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
      t_mic <= '0;
      t_ref <= '0;
      seen_mic <= 1'b0;
      seen_ref <= 1'b0;
      res <= '0;
    end else begin
      busy <= next_busy;
      done <= next_done;
      cnt <= next_cnt;
      t_mic <= next_t_mic;
      t_ref <= next_t_ref;
      seen_mic <= next_seen_mic;
      seen_ref <= next_seen_ref;
      res <= next_res;
    end
  end

  assign busy_out = busy;
  assign done_out = done;
  assign result_out = res;

endmodule : rda_estimator

// File: rtl/rda_pkg.sv
package rda_pkg;

  // ==========================================================================
  // Sample, delay and timing constants
  // ==========================================================================
  localparam int SAMPLE_W = 16;
  localparam int SAMPLE_RATE_HZ = 16000;
  localparam int MAX_DELAY_MS = 150;
  localparam int MAX_DELAY_SAMPLES = SAMPLE_RATE_HZ / 1000 * MAX_DELAY_MS;
  localparam int DELAY_W = 12;
  localparam int LAG_W = 13;
  localparam logic [DELAY_W-1:0] MAX_DELAY = DELAY_W'(MAX_DELAY_SAMPLES);
  localparam int DEPTH = 4096;
  localparam int ADDR_W = 12;
  localparam int SCAN_W = 12;
  localparam logic [SCAN_W-1:0] SCAN_LEN = 12'h800;
  localparam int ACC_W = 48;

  // ==========================================================================
  // Reset values and encodings
  // ==========================================================================
  localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;
  localparam logic PATH_REF = 1'b0;
  localparam logic PATH_MIC = 1'b1;

  typedef enum logic [1:0] {
    RDA_MODE_STARTUP = 2'h0,
    RDA_MODE_MANUAL = 2'h1,
    RDA_MODE_AUTO = 2'h2
  } rda_mode_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } rda_stereo_t;

  typedef struct packed {
    logic [DELAY_W-1:0] amount;
    logic path;
  } rda_delay_t;

endpackage : rda_pkg
